// ### sideband_pkg.sv
package sideband_pkg;

    // Channel identifier layout
    localparam int PKG_ID_MSB = 7;
    localparam int PKG_ID_LSB = 5;
    localparam int CHAN_ID_MSB = 4;
    localparam int CHAN_ID_LSB = 0;
    localparam logic [4:0] WHOLE_PKG_ID = 5'h1F;
    localparam int NUM_CHANNELS = 2;
    localparam int AEN_TYPES = 3;
    localparam int VLAN_ENTRIES = 4;
    localparam int MAC_ENTRIES = 2;

    // Reset values
    localparam logic HW_ARB_RESET = 1'h1;
    localparam logic FLOW_CTRL_RESET = 1'h0;

    // Command opcodes
    typedef enum logic [4:0] {
        CMD_CLEAR_INIT = 5'h00,
        CMD_SELECT_PKG = 5'h01,
        CMD_DESELECT_PKG = 5'h02,
        CMD_ENABLE_CHAN = 5'h03,
        CMD_DISABLE_CHAN = 5'h04,
        CMD_RESET_CHAN = 5'h05,
        CMD_ENABLE_NET_TX = 5'h06,
        CMD_DISABLE_NET_TX = 5'h07,
        CMD_AEN_ENABLE = 5'h08,
        CMD_SET_VLAN = 5'h0B,
        CMD_ENABLE_VLAN = 5'h0C,
        CMD_DISABLE_VLAN = 5'h0D,
        CMD_SET_MAC = 5'h0E,
        CMD_ENABLE_BCAST = 5'h10,
        CMD_DISABLE_BCAST = 5'h11,
        CMD_ENABLE_MCAST = 5'h12,
        CMD_DISABLE_MCAST = 5'h13,
        CMD_SET_FLOW_CTRL = 5'h14,
        CMD_OEM = 5'h1F
    } cmd_op_t;

    // Response codes
    typedef enum logic [1:0] {
        RESP_OK = 2'h0,
        RESP_FAILED = 2'h1,
        RESP_UNSUPPORTED = 2'h2
    } resp_code_t;

    typedef enum logic [1:0] {
        REASON_NONE = 2'h0,
        REASON_INIT_REQUIRED = 2'h1,
        REASON_BAD_CHANNEL = 2'h2,
        REASON_BAD_SCOPE = 2'h3
    } reason_t;

    // Command from the packet parser
    typedef struct packed {
        logic [7:0] chan_id;
        cmd_op_t op;
        logic [15:0] param;
    } cmd_t;

    // Response towards the packet builder
    typedef struct packed {
        logic [7:0] chan_id;
        cmd_op_t op;
        resp_code_t code;
        reason_t reason;
    } resp_t;

    // Per-channel settings visible to the datapath
    typedef struct packed {
        logic initial_state;
        logic chan_en;
        logic net_tx_en;
        logic [AEN_TYPES-1:0] aen_en;
        logic [MAC_ENTRIES-1:0] mac_en;
        logic bcast_en;
        logic mcast_en;
        logic [1:0] vlan_mode;
        logic vlan_en;
        logic [VLAN_ENTRIES-1:0] vlan_entry_en;
    } chan_cfg_t;

endpackage

// ### sideband_channel_addressing_config.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Reset Channel command puts the addressed channel into the initial state.
// - Settings outside the initial state set are kept after channel reset.
// - Channel identifier is package id in bits 7..5, channel in 4..0.
// - Package id low two bits configurable by pins, top bit fixed zero.
// - Internal channel ids run sequentially from zero, one per channel.
// - Internal channel id 0x1F addresses the whole package.
// - Identifiers fully decoded; no two values select the same channel.
// - Identifiers come from pins and survive sideband power-downs.
// - Package-specific commands executed only with internal id 0x1F.
// - Channel commands need id other than 0x1F and a valid channel.
// - Select Package latches the hardware arbitration enable.
// - Package holds arbitration enable and flow control, shared by all channels.
// - Channel enable gates unsolicited sends while selected; responses always allowed.
// - Network transmit forwards only source-MAC matches, and only while enabled.
// - Per-type event enables from AEN Enable; only enabled events sent.
// - Inbound packets filtered by unicast, broadcast, multicast and VLAN settings.
// - VLAN entries stored; Enable/Disable VLAN set mode and on/off.
// - Initial-state channel fails commands other than Clear Initial State, Reset Channel and OEM with initialization required.
// - Entering initial state clears channel, transmit, events, MAC and VLAN enables.
// - With arbitration on, transmit only while holding token and selected.
module sideband_channel_addressing_config
    import sideband_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Identity straps
    input wire logic [1:0] pkg_id_pins,
    // Command in, response out
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    output logic resp_valid,
    output resp_t resp,
    // Package state
    output logic pkg_selected,
    output logic hw_arb_en,
    output logic flow_ctrl_en,
    output logic [1:0] flow_ctrl_mode,
    input wire logic arb_token,
    output logic bus_tx_allowed,
    // Channel settings
    output chan_cfg_t [NUM_CHANNELS-1:0] chan_cfg,
    // Unsolicited sends
    input wire logic [NUM_CHANNELS-1:0] unsol_req,
    output logic [NUM_CHANNELS-1:0] unsol_allowed,
    input wire logic [NUM_CHANNELS-1:0][AEN_TYPES-1:0] aen_event,
    output logic [NUM_CHANNELS-1:0][AEN_TYPES-1:0] aen_send,
    // Pass-through to network
    input wire logic [NUM_CHANNELS-1:0] ptx_valid,
    input wire logic [NUM_CHANNELS-1:0][47:0] ptx_src_mac,
    output logic [NUM_CHANNELS-1:0] ptx_forward,
    // Inbound filter
    input wire logic [NUM_CHANNELS-1:0] rx_valid,
    input wire logic [NUM_CHANNELS-1:0][47:0] rx_dst_mac,
    input wire logic [NUM_CHANNELS-1:0] rx_tagged,
    input wire logic [NUM_CHANNELS-1:0][11:0] rx_vlan_id,
    output logic [NUM_CHANNELS-1:0] rx_accept
);

    logic [1:0] pins_meta_r;
    logic [1:0] pins_sync_r;
    logic [2:0] pkg_id_r;
    logic sel_r;
    logic hw_arb_r;
    logic flow_r;
    logic [1:0] flow_mode_r;
    logic resp_valid_r;
    resp_t resp_r;
    chan_cfg_t [NUM_CHANNELS-1:0] cfg_r;

    logic [2:0] cmd_pkg;
    logic [4:0] cmd_chan;
    logic pkg_hit;
    logic whole_pkg;
    logic chan_valid;
    logic [NUM_CHANNELS-1:0] chan_hit;
    logic is_pkg_cmd;
    logic exec_pkg;
    logic exec_chan;

    // True for Select and Deselect Package; Set Flow Control is added in is_pkg_cmd
    function automatic logic pkg_scope(input cmd_op_t op);
        return op == CMD_SELECT_PKG || op == CMD_DESELECT_PKG;
    endfunction

    // Identity straps, synchronised and resampled every cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta_r <= 2'h0;
            pins_sync_r <= 2'h0;
        end else begin
            pins_meta_r <= pkg_id_pins;
            pins_sync_r <= pins_meta_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pkg_id_r <= 3'h0;
        end else begin
            pkg_id_r <= {1'b0, pins_sync_r};
        end
    end

    // Command decode
    assign cmd_pkg = cmd.chan_id[PKG_ID_MSB:PKG_ID_LSB];
    assign cmd_chan = cmd.chan_id[CHAN_ID_MSB:CHAN_ID_LSB];
    assign pkg_hit = cmd_valid && (cmd_pkg == pkg_id_r);
    assign whole_pkg = (cmd_chan == WHOLE_PKG_ID);
    assign chan_valid = (cmd_chan < 5'(NUM_CHANNELS));
    assign is_pkg_cmd = pkg_scope(cmd.op) || cmd.op == CMD_SET_FLOW_CTRL;
    assign exec_pkg = pkg_hit && whole_pkg && is_pkg_cmd;
    assign exec_chan = pkg_hit && !whole_pkg && chan_valid && !is_pkg_cmd;

    generate
        for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_hit
            assign chan_hit[c] = exec_chan && (cmd_chan == 5'(c));
        end
    endgenerate

    // Package-wide settings
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= 1'b0;
            hw_arb_r <= HW_ARB_RESET;
            flow_r <= FLOW_CTRL_RESET;
            flow_mode_r <= 2'h0;
        end else if (exec_pkg) begin
            unique case (cmd.op)
                CMD_SELECT_PKG: begin
                    sel_r <= 1'b1;
                    hw_arb_r <= ~cmd.param[0];
                end
                CMD_DESELECT_PKG: begin
                    sel_r <= 1'b0;
                end
                CMD_SET_FLOW_CTRL: begin
                    flow_r <= |cmd.param[1:0];
                    flow_mode_r <= cmd.param[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Per-channel settings
    generate
        for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
            logic blocked;
            assign blocked = cfg_r[c].initial_state && cmd.op != CMD_CLEAR_INIT;

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cfg_r[c] <= '0;
                    cfg_r[c].initial_state <= 1'b1;
                end else if (chan_hit[c]) begin
                    if (cmd.op == CMD_RESET_CHAN) begin
                        cfg_r[c].initial_state <= 1'b1;
                        cfg_r[c].chan_en <= 1'b0;
                        cfg_r[c].net_tx_en <= 1'b0;
                        cfg_r[c].aen_en <= '0;
                        cfg_r[c].mac_en <= '0;
                        cfg_r[c].vlan_en <= 1'b0;
                        cfg_r[c].vlan_entry_en <= '0;
                    end else if (cmd.op == CMD_CLEAR_INIT) begin
                        cfg_r[c].initial_state <= 1'b0;
                    end else if (!blocked) begin
                        unique case (cmd.op)
                            CMD_ENABLE_CHAN: cfg_r[c].chan_en <= 1'b1;
                            CMD_DISABLE_CHAN: cfg_r[c].chan_en <= 1'b0;
                            CMD_ENABLE_NET_TX: cfg_r[c].net_tx_en <= 1'b1;
                            CMD_DISABLE_NET_TX: cfg_r[c].net_tx_en <= 1'b0;
                            CMD_AEN_ENABLE: begin
                                cfg_r[c].aen_en <= cmd.param[AEN_TYPES-1:0];
                            end
                            CMD_SET_MAC: begin
                                cfg_r[c].mac_en[cmd.param[12]] <= cmd.param[13];
                            end
                            CMD_ENABLE_BCAST: cfg_r[c].bcast_en <= 1'b1;
                            CMD_DISABLE_BCAST: cfg_r[c].bcast_en <= 1'b0;
                            CMD_ENABLE_MCAST: cfg_r[c].mcast_en <= 1'b1;
                            CMD_DISABLE_MCAST: cfg_r[c].mcast_en <= 1'b0;
                            CMD_SET_VLAN: begin
                                cfg_r[c].vlan_entry_en[cmd.param[13:12]] <= cmd.param[14];
                            end
                            CMD_ENABLE_VLAN: begin
                                cfg_r[c].vlan_en <= 1'b1;
                                cfg_r[c].vlan_mode <= cmd.param[1:0];
                            end
                            CMD_DISABLE_VLAN: cfg_r[c].vlan_en <= 1'b0;
                            default: begin
                            end
                        endcase
                    end
                end
            end

            // Address tables; entry data kept across channel reset
            logic [47:0] mac_tab [MAC_ENTRIES];
            logic [11:0] vlan_tab [VLAN_ENTRIES];
            always_ff @(posedge clk) begin
                if (chan_hit[c] && !blocked && cmd.op == CMD_SET_MAC) begin
                    mac_tab[cmd.param[12]] <= {36'h0, cmd.param[11:0]};
                end
                if (chan_hit[c] && !blocked && cmd.op == CMD_SET_VLAN) begin
                    vlan_tab[cmd.param[13:12]] <= cmd.param[11:0];
                end
            end

            // Datapath gating
            logic src_match;
            logic uc_match;
            logic vlan_ok;
            always_comb begin
                src_match = 1'b0;
                uc_match = 1'b0;
                vlan_ok = !cfg_r[c].vlan_en || !rx_tagged[c];
                for (int m = 0; m < MAC_ENTRIES; m++) begin
                    src_match |= cfg_r[c].mac_en[m] && ptx_src_mac[c] == mac_tab[m];
                    uc_match |= cfg_r[c].mac_en[m] && rx_dst_mac[c] == mac_tab[m];
                end
                for (int v = 0; v < VLAN_ENTRIES; v++) begin
                    vlan_ok |= rx_tagged[c] && cfg_r[c].vlan_entry_en[v]
                        && rx_vlan_id[c] == vlan_tab[v];
                end
            end

            assign unsol_allowed[c] = unsol_req[c] && cfg_r[c].chan_en && bus_tx_allowed;
            assign aen_send[c] = aen_event[c] & cfg_r[c].aen_en
                & {AEN_TYPES{cfg_r[c].chan_en && bus_tx_allowed}};
            assign ptx_forward[c] = ptx_valid[c] && cfg_r[c].net_tx_en && src_match;
            assign rx_accept[c] = rx_valid[c] && cfg_r[c].chan_en && vlan_ok && (uc_match
                || (&rx_dst_mac[c] && !cfg_r[c].bcast_en)
                || (rx_dst_mac[c][40] && !(&rx_dst_mac[c]) && !cfg_r[c].mcast_en));
        end
    endgenerate

    // Response generation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid_r <= 1'b0;
            resp_r <= '0;
        end else begin
            resp_valid_r <= pkg_hit;
            resp_r.chan_id <= cmd.chan_id;
            resp_r.op <= cmd.op;
            resp_r.code <= RESP_OK;
            resp_r.reason <= REASON_NONE;
            if (whole_pkg && !is_pkg_cmd) begin
                resp_r.code <= RESP_FAILED;
                resp_r.reason <= REASON_BAD_SCOPE;
            end else if (!whole_pkg && (is_pkg_cmd || !chan_valid)) begin
                resp_r.code <= RESP_FAILED;
                resp_r.reason <= REASON_BAD_CHANNEL;
            end else if (exec_chan && cfg_r[cmd_chan[0]].initial_state
                         && cmd.op != CMD_CLEAR_INIT && cmd.op != CMD_RESET_CHAN
                         && cmd.op != CMD_OEM) begin
                resp_r.code <= RESP_FAILED;
                resp_r.reason <= REASON_INIT_REQUIRED;
            end
        end
    end

    assign resp_valid = resp_valid_r;
    assign resp = resp_r;
    assign pkg_selected = sel_r;
    assign hw_arb_en = hw_arb_r;
    assign flow_ctrl_en = flow_r;
    assign flow_ctrl_mode = flow_mode_r;
    assign bus_tx_allowed = sel_r && (!hw_arb_r || arb_token);
    assign chan_cfg = cfg_r;

endmodule // sideband_channel_addressing_config
`default_nettype wire

// ### sideband_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sideband_chk
    import sideband_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Commands and responses
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    input wire logic resp_valid,
    input wire resp_t resp,
    // Package state
    input wire logic pkg_selected,
    input wire logic hw_arb_en,
    input wire logic arb_token,
    input wire logic bus_tx_allowed,
    // Channel state and sends
    input wire chan_cfg_t [NUM_CHANNELS-1:0] chan_cfg,
    input wire logic [NUM_CHANNELS-1:0][AEN_TYPES-1:0] aen_event,
    input wire logic [NUM_CHANNELS-1:0][AEN_TYPES-1:0] aen_send,
    input wire logic [NUM_CHANNELS-1:0] ptx_forward
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    resp_follows_a: assert property (resp_valid |-> $past(cmd_valid) &&
        resp.chan_id == $past(cmd.chan_id) && resp.op == $past(cmd.op))
        else $error("response without matching command");
    foreign_silent_a: assert property (cmd_valid && cmd.chan_id[7] |=> !resp_valid)
        else $error("response to foreign package id");
    arb_gate_a: assert property (bus_tx_allowed == (pkg_selected && (!hw_arb_en || arb_token)))
        else $error("bus transmit permission wrong");
    aen_gate_a: assert property (aen_send[0] == (aen_event[0] & chan_cfg[0].aen_en &
        {AEN_TYPES{chan_cfg[0].chan_en && bus_tx_allowed}})) else $error("event send wrong");
    ptx_off_a: assert property (!chan_cfg[0].net_tx_en |-> !ptx_forward[0])
        else $error("forward while transmit disabled");
    chan_reset_a: assert property (resp_valid && resp.op == CMD_RESET_CHAN &&
        resp.chan_id[4:0] == 5'h00 |-> chan_cfg[0].initial_state && !chan_cfg[0].chan_en &&
        !chan_cfg[0].net_tx_en && chan_cfg[0].aen_en == '0 && chan_cfg[0].mac_en == '0 &&
        !chan_cfg[0].vlan_en) else $error("channel reset left settings");
    init_fail_a: assert property (resp_valid && resp.chan_id[4:0] == 5'h00 &&
        $past(chan_cfg[0].initial_state) && resp.op == CMD_ENABLE_CHAN |->
        resp.code == RESP_FAILED && resp.reason == REASON_INIT_REQUIRED)
        else $error("initial state not reported");
    bad_scope_a: assert property (resp_valid && resp.chan_id[4:0] == WHOLE_PKG_ID &&
        resp.op == CMD_ENABLE_CHAN |-> resp.code == RESP_FAILED && resp.reason == REASON_BAD_SCOPE)
        else $error("channel command at package scope accepted");
    bad_chan_a: assert property (resp_valid && resp.chan_id[4:0] == 5'h02 |->
        resp.code == RESP_FAILED && resp.reason == REASON_BAD_CHANNEL)
        else $error("absent channel accepted");
    sel_arb_a: assert property (resp_valid && resp.op == CMD_SELECT_PKG && resp.code == RESP_OK
        |-> pkg_selected && hw_arb_en == !$past(cmd.param[0])) else $error("select latch wrong");
    cover property (resp_valid && resp.op == CMD_RESET_CHAN);
    cover property (aen_send[0] != '0);
    cover property (ptx_forward[0]);
endmodule // sideband_chk
bind sideband_channel_addressing_config sideband_chk i_sideband_chk (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .resp_valid(resp_valid),
    .resp(resp), .pkg_selected(pkg_selected), .hw_arb_en(hw_arb_en), .arb_token(arb_token),
    .bus_tx_allowed(bus_tx_allowed), .chan_cfg(chan_cfg), .aen_event(aen_event),
    .aen_send(aen_send), .ptx_forward(ptx_forward)
);
`default_nettype wire

// ### mgmt_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_ctrl_model
    import sideband_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command out, response in
    output logic cmd_valid,
    output cmd_t cmd,
    input wire logic resp_valid,
    input wire resp_t resp
);
    logic got;
    resp_t seen;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // One package on this bus, so selecting never leaves two drivers
    task automatic send(input logic [7:0] id, input cmd_op_t op, input logic [15:0] p);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = '{chan_id: id, op: op, param: p};
        @(negedge clk);
        got = resp_valid;
        seen = resp;
        cmd_valid = 1'b0;
        cmd = cmd_t'(~cmd);
    endtask
endmodule // mgmt_ctrl_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top
    import sideband_pkg::*;
;
    localparam logic [2:0] PID = 3'h2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] pkg_id_pins = 2'h2;
    logic cmd_valid, resp_valid, pkg_selected, hw_arb_en, flow_ctrl_en, arb_token, bus_tx_allowed;
    cmd_t cmd;
    resp_t resp;
    logic [1:0] flow_ctrl_mode;
    chan_cfg_t [NUM_CHANNELS-1:0] chan_cfg;
    logic [NUM_CHANNELS-1:0] unsol_req, unsol_allowed, ptx_valid, ptx_forward;
    logic [NUM_CHANNELS-1:0] rx_valid, rx_tagged, rx_accept;
    logic [NUM_CHANNELS-1:0][AEN_TYPES-1:0] aen_event, aen_send;
    logic [NUM_CHANNELS-1:0][47:0] ptx_src_mac, rx_dst_mac;
    logic [NUM_CHANNELS-1:0][11:0] rx_vlan_id;
    logic [7:0] foreign [2] = '{8'h3F, 8'hDF};
    cmd_op_t cfg_op [6] = '{CMD_ENABLE_CHAN, CMD_ENABLE_NET_TX, CMD_AEN_ENABLE, CMD_SET_MAC,
        CMD_SET_VLAN, CMD_ENABLE_VLAN};
    logic [15:0] cfg_p [6] = '{16'h0000, 16'h0000, 16'h0005, 16'h2123, 16'h5064, 16'h0001};
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    sideband_channel_addressing_config i_sideband_channel_addressing_config (
        .clk(clk), .rst_n(rst_n), .pkg_id_pins(pkg_id_pins), .cmd_valid(cmd_valid), .cmd(cmd),
        .resp_valid(resp_valid), .resp(resp), .pkg_selected(pkg_selected), .hw_arb_en(hw_arb_en),
        .flow_ctrl_en(flow_ctrl_en), .flow_ctrl_mode(flow_ctrl_mode), .arb_token(arb_token),
        .bus_tx_allowed(bus_tx_allowed), .chan_cfg(chan_cfg), .unsol_req(unsol_req),
        .unsol_allowed(unsol_allowed), .aen_event(aen_event), .aen_send(aen_send),
        .ptx_valid(ptx_valid), .ptx_src_mac(ptx_src_mac), .ptx_forward(ptx_forward),
        .rx_valid(rx_valid), .rx_dst_mac(rx_dst_mac), .rx_tagged(rx_tagged),
        .rx_vlan_id(rx_vlan_id), .rx_accept(rx_accept));
    mgmt_ctrl_model i_mgmt_ctrl_model (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .resp_valid(resp_valid), .resp(resp));
    task automatic end_sim;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    // Command to own package, response checked
    task automatic do_cmd(input logic [4:0] ch, input cmd_op_t op, input logic [15:0] p,
        input resp_code_t ec, input reason_t er);
        i_mgmt_ctrl_model.send({PID, ch}, op, p);
        `CHK("resp_valid", 1'b1, i_mgmt_ctrl_model.got)
        `CHK("resp_code", ec, i_mgmt_ctrl_model.seen.code)
        `CHK("resp_reason", er, i_mgmt_ctrl_model.seen.reason)
        `CHK("resp_chan", {PID, ch}, i_mgmt_ctrl_model.seen.chan_id)
    endtask
    initial begin
        {arb_token, unsol_req, ptx_valid, rx_valid, rx_tagged, aen_event, ptx_src_mac} = '0;
        rx_vlan_id = '0;
        rx_dst_mac = '1;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        do_cmd(5'h00, CMD_ENABLE_CHAN, 16'h0000, RESP_FAILED, REASON_INIT_REQUIRED);
        foreach (foreign[i]) begin
            i_mgmt_ctrl_model.send(foreign[i], CMD_SELECT_PKG, 16'h0000);
            `CHK("foreign_silent", 1'b0, i_mgmt_ctrl_model.got)
        end
        do_cmd(5'h1F, CMD_SELECT_PKG, 16'h0001, RESP_OK, REASON_NONE);
        `CHK("hw_arb_off", 1'b0, hw_arb_en)
        do_cmd(5'h1F, CMD_SELECT_PKG, 16'h0000, RESP_OK, REASON_NONE);
        `CHK("hw_arb_on", 1'b1, hw_arb_en)
        do_cmd(5'h00, CMD_CLEAR_INIT, 16'h0000, RESP_OK, REASON_NONE);
        do_cmd(5'h01, CMD_CLEAR_INIT, 16'h0000, RESP_OK, REASON_NONE);
        do_cmd(5'h02, CMD_CLEAR_INIT, 16'h0000, RESP_FAILED, REASON_BAD_CHANNEL);
        do_cmd(5'h1F, CMD_ENABLE_CHAN, 16'h0000, RESP_FAILED, REASON_BAD_SCOPE);
        do_cmd(5'h00, CMD_SELECT_PKG, 16'h0000, RESP_FAILED, REASON_BAD_CHANNEL);
        foreach (cfg_op[i]) do_cmd(5'h00, cfg_op[i], cfg_p[i], RESP_OK, REASON_NONE);
        do_cmd(5'h1F, CMD_SET_FLOW_CTRL, 16'h0002, RESP_OK, REASON_NONE);
        `CHK("flow", 3'h5, {flow_ctrl_mode, flow_ctrl_en})
        `CHK("vlan_entry", 4'h2, chan_cfg[0].vlan_entry_en)
        `CHK("vlan_on", 3'h3, {chan_cfg[0].vlan_mode, chan_cfg[0].vlan_en})
        do_cmd(5'h00, CMD_DISABLE_VLAN, 16'h0000, RESP_OK, REASON_NONE);
        `CHK("vlan_off", 1'b0, chan_cfg[0].vlan_en)
        aen_event = '1;
        unsol_req = 2'h3;
        ptx_valid = 2'h3;
        ptx_src_mac = {48'h000000000123, 48'h000000000123};
        rx_valid = 2'h3;
        #1;
        `CHK("tx_no_token", 1'b0, bus_tx_allowed)
        `CHK("aen_no_token", 6'h00, aen_send)
        `CHK("rx_bcast", 2'h1, rx_accept)
        `CHK("ptx_match", 2'h1, ptx_forward)
        @(negedge clk);
        arb_token = 1'b1;
        ptx_src_mac[0] = 48'h000000000124;
        #1;
        `CHK("aen_sent", 6'h05, aen_send)
        `CHK("unsol", 2'h1, unsol_allowed)
        `CHK("ptx_nomatch", 2'h0, ptx_forward)
        do_cmd(5'h00, CMD_ENABLE_BCAST, 16'h0000, RESP_OK, REASON_NONE);
        `CHK("rx_bcast_drop", 2'h0, rx_accept)
        do_cmd(5'h1F, CMD_DESELECT_PKG, 16'h0000, RESP_OK, REASON_NONE);
        `CHK("unsol_desel", 2'h0, unsol_allowed)
        do_cmd(5'h00, CMD_RESET_CHAN, 16'h0000, RESP_OK, REASON_NONE);
        `CHK("chan0_init", 9'h100, {chan_cfg[0].initial_state, chan_cfg[0].chan_en,
            chan_cfg[0].net_tx_en, chan_cfg[0].aen_en, chan_cfg[0].mac_en, chan_cfg[0].vlan_en})
        `CHK("chan1_kept", 1'b0, chan_cfg[1].initial_state)
        `CHK("pkg_kept", 4'hD, {hw_arb_en, flow_ctrl_mode, flow_ctrl_en})
        do_cmd(5'h00, CMD_ENABLE_CHAN, 16'h0000, RESP_FAILED, REASON_INIT_REQUIRED);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
